/* inc/pmcr_pkg.sv */
// Constants shared by the power management capability register set.
`default_nettype none
package pmcr_pkg;

  // ==========================================================================
  // Configuration space byte addresses
  localparam logic [7:0] ADDR_CAP_LO = 8'hde;
  localparam logic [7:0] ADDR_CAP_HI = 8'hdf;
  localparam logic [7:0] ADDR_CSR_LO = 8'he0;
  localparam logic [7:0] ADDR_CSR_HI = 8'he1;
  localparam logic [7:0] ADDR_BSE = 8'he2;
  localparam logic [7:0] ADDR_DATA = 8'he3;

  // ==========================================================================
  // Byte lanes of the register set, in address order
  localparam int NUM_BYTES = 6;
  localparam logic [2:0] IDX_CAP_LO = 3'h0;
  localparam logic [2:0] IDX_CAP_HI = 3'h1;
  localparam logic [2:0] IDX_CSR_LO = 3'h2;
  localparam logic [2:0] IDX_CSR_HI = 3'h3;
  localparam logic [2:0] IDX_BSE = 3'h4;
  localparam logic [2:0] IDX_DATA = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ==========================================================================
  // Reset values and write masks, one byte per lane, lane 0 lowest
  localparam logic [NUM_BYTES-1:0][7:0] RESET_BYTES =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h7e, 8'h01};
  // Bits that any configuration write may change.
  localparam logic [NUM_BYTES-1:0][7:0] MASK_ALWAYS =
    {8'h00, 8'h00, 8'h81, 8'h03, 8'h00, 8'h00};
  // Bits that change only while the unlock is set, or from the EEPROM.
  localparam logic [NUM_BYTES-1:0][7:0] MASK_UNLOCK =
    {8'hff, 8'h00, 8'h1e, 8'h00, 8'hfe, 8'h3f};

  // ==========================================================================
  // Field values used by the logic
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D3HOT = 2'h3;
  localparam logic [2:0] CAP_VERSION_RST = 3'h1;
  localparam logic [4:0] PME_MASK_RST = 5'h0f;
  localparam logic [5:0] BSE_RSVD = 6'h00;
  localparam int NUM_SEC_CLOCKS = 5;

endpackage
`default_nettype wire

/* hw/pmcr_byte_lane.sv */
// Next-value logic for one byte of register storage with its write masking.
`timescale 1ns/1ns
`default_nettype none
module pmcr_byte_lane (
  input wire logic [7:0] cur,
  input wire logic [7:0] wdata,
  input wire logic [7:0] mask_always,
  input wire logic [7:0] mask_unlock,
  input wire logic unlock,
  input wire logic wr,
  output logic [7:0] nxt
);

  logic [7:0] mask;

  always_comb begin
    mask = mask_always | (unlock ? mask_unlock : 8'h00);
    nxt = wr ? ((cur & ~mask) | (wdata & mask)) : cur;
  end

endmodule
`default_nettype wire

/* hw/pmcr_regs.sv */
// Power management capability registers of a bridge, config space view.
//
// How it works
// - Capability version in bits 2:0 resets to 001b.
// - Capability bits 3 and 4 reset to zero; no wake clock or aux power flag.
// - Capability bit 5 resets to zero; no special initialisation needed.
// - Capability bits 9 and 10 reset to one, advertising D1 and D2.
// - Wake support mask in bits 15:11 resets to 01111b.
// - Writable capability fields and data byte need unlock or EEPROM load.
// - Power state bits 1:0: D0, D1, D2, D3hot; resets to D0.
// - In D3hot with clock control pin high, the five secondary clocks stop.
// - Wake enable bit 8 and wake status bit 15 reset to zero, writable.
// - Data select 12:9 unlock-writable; data scale 14:13 always zero.
// - Extension bit 6 follows the bus power clock control pin.
// - Extension bit 7 follows the bus power clock control pin too.
// - Data byte resets to zero; EEPROM or unlocked write loads it.
// - Unlock bit opens read-only fields; software clears it afterwards.
// - Unlock has no effect on writes to status bits 15 and 8.
`timescale 1ns/1ns
`default_nettype none
module pmcr_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic eeprom_load,
  input wire logic [7:0] eeprom_addr,
  input wire logic [7:0] eeprom_data,
  input wire logic readonly_write_unlock_ctrl,
  input wire logic bus_power_clock_ctrl_pin,
  output logic [pmcr_pkg::NUM_SEC_CLOCKS-1:0] secondary_clock_outputs,
  output logic [15:0] pm_capabilities,
  output logic [15:0] pm_control_status,
  output logic [7:0] pm_data_byte
);

  // ==========================================================================
  // Address decode
  function automatic logic [2:0] pmcr_lane(input logic [7:0] addr);
    logic [2:0] idx;
    idx = pmcr_pkg::IDX_NONE;
    if (addr == pmcr_pkg::ADDR_CAP_LO) begin
      idx = pmcr_pkg::IDX_CAP_LO;
    end else if (addr == pmcr_pkg::ADDR_CAP_HI) begin
      idx = pmcr_pkg::IDX_CAP_HI;
    end else if (addr == pmcr_pkg::ADDR_CSR_LO) begin
      idx = pmcr_pkg::IDX_CSR_LO;
    end else if (addr == pmcr_pkg::ADDR_CSR_HI) begin
      idx = pmcr_pkg::IDX_CSR_HI;
    end else if (addr == pmcr_pkg::ADDR_BSE) begin
      idx = pmcr_pkg::IDX_BSE;
    end else if (addr == pmcr_pkg::ADDR_DATA) begin
      idx = pmcr_pkg::IDX_DATA;
    end
    return idx;
  endfunction

  // ==========================================================================
  // State
  typedef struct packed {
    logic [pmcr_pkg::NUM_BYTES-1:0][7:0] bytes;
    logic [7:0] rdata;
    logic [pmcr_pkg::NUM_SEC_CLOCKS-1:0] clk_run;
  } pmcr_state_s;

  pmcr_state_s state_r;
  pmcr_state_s state_nxt;

  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [7:0] src_data;
  logic src_unlock;
  logic [pmcr_pkg::NUM_BYTES-1:0][7:0] lane_nxt;
  logic clk_stop;

  // An EEPROM load wins over a configuration write in the same cycle; the
  // loader runs straight after reset, before software touches the bridge.
  always_comb begin
    wr_idx = eeprom_load ? pmcr_lane(eeprom_addr) : pmcr_lane(cfg_addr);
    src_data = eeprom_load ? eeprom_data : cfg_wdata;
    src_unlock = eeprom_load | readonly_write_unlock_ctrl;
    rd_idx = pmcr_lane(cfg_addr);
  end

  // ==========================================================================
  // Byte lanes
  // Masks hold reserved and fixed bits at their reset value.
  genvar g;
  generate
    for (g = 0; g < pmcr_pkg::NUM_BYTES; g++) begin : g_lane
      pmcr_byte_lane u_lane (
        .cur(state_r.bytes[g]),
        .wdata(src_data),
        .mask_always(pmcr_pkg::MASK_ALWAYS[g]),
        .mask_unlock(pmcr_pkg::MASK_UNLOCK[g]),
        .unlock(src_unlock),
        .wr((eeprom_load | cfg_wr) && wr_idx == 3'(g)),
        .nxt(lane_nxt[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.bytes = lane_nxt;
    clk_stop = state_r.bytes[pmcr_pkg::IDX_CSR_LO][1:0] ==
      pmcr_pkg::PSTATE_D3HOT && bus_power_clock_ctrl_pin;
    state_nxt.clk_run = {pmcr_pkg::NUM_SEC_CLOCKS{~clk_stop}};
    if (cfg_rd) begin
      if (rd_idx == pmcr_pkg::IDX_BSE) begin
        state_nxt.rdata = {bus_power_clock_ctrl_pin,
          bus_power_clock_ctrl_pin, pmcr_pkg::BSE_RSVD};
      end else if (rd_idx == pmcr_pkg::IDX_NONE) begin
        state_nxt.rdata = 8'h00;
      end else begin
        state_nxt.rdata = state_r.bytes[rd_idx];
      end
    end
    if (reset) begin
      state_nxt.bytes = pmcr_pkg::RESET_BYTES;
      state_nxt.rdata = 8'h00;
      state_nxt.clk_run = {pmcr_pkg::NUM_SEC_CLOCKS{1'b1}};
    end
  end

  always_ff @(posedge clk) begin
    state_r <= state_nxt;
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    cfg_rdata = state_r.rdata;
    secondary_clock_outputs = state_r.clk_run;
    pm_capabilities = {state_r.bytes[pmcr_pkg::IDX_CAP_HI],
      state_r.bytes[pmcr_pkg::IDX_CAP_LO]};
    pm_control_status = {state_r.bytes[pmcr_pkg::IDX_CSR_HI],
      state_r.bytes[pmcr_pkg::IDX_CSR_LO]};
    pm_data_byte = state_r.bytes[pmcr_pkg::IDX_DATA];
  end

  // ==========================================================================
  // Checks
  version_reset_a: assert property (
    @(posedge clk) reset |=>
      pm_capabilities[2:0] == pmcr_pkg::CAP_VERSION_RST)
    else $error("Capability version wrong after reset.");

  pme_flags_reset_a: assert property (
    @(posedge clk) reset |=> pm_capabilities[4:3] == 2'h0)
    else $error("Wake clock or aux power flag set after reset.");

  dsi_reset_a: assert property (
    @(posedge clk) reset |=> !pm_capabilities[5])
    else $error("Special initialisation flag set after reset.");

  d1_d2_reset_a: assert property (
    @(posedge clk) reset |=> pm_capabilities[10:9] == 2'h3)
    else $error("D1 or D2 support missing after reset.");

  pme_mask_reset_a: assert property (
    @(posedge clk) reset |=>
      pm_capabilities[15:11] == pmcr_pkg::PME_MASK_RST &&
      pm_control_status == 16'h0000 && pm_data_byte == 8'h00)
    else $error("Wake mask or control word wrong after reset.");

  locked_cap_a: assert property (
    @(posedge clk) disable iff (reset)
      cfg_wr && !eeprom_load && !readonly_write_unlock_ctrl &&
      (cfg_addr == pmcr_pkg::ADDR_CAP_LO ||
       cfg_addr == pmcr_pkg::ADDR_CAP_HI) |=> $stable(pm_capabilities))
    else $error("Locked capability word changed.");

  pstate_write_a: assert property (
    @(posedge clk) disable iff (reset)
      cfg_wr && !eeprom_load && cfg_addr == pmcr_pkg::ADDR_CSR_LO |=>
      pm_control_status[1:0] == $past(cfg_wdata[1:0]) &&
      pm_control_status[7:2] == 6'h00)
    else $error("Power state write not taken.");

  clock_stop_a: assert property (
    @(posedge clk) disable iff (reset)
      pm_control_status[1:0] == pmcr_pkg::PSTATE_D3HOT &&
      bus_power_clock_ctrl_pin |=> secondary_clock_outputs == 5'h00)
    else $error("Secondary clocks run in D3hot.");

  pme_bits_a: assert property (
    @(posedge clk) disable iff (reset)
      cfg_wr && !eeprom_load && cfg_addr == pmcr_pkg::ADDR_CSR_HI |=>
      pm_control_status[15] == $past(cfg_wdata[7]) &&
      pm_control_status[8] == $past(cfg_wdata[0]))
    else $error("Wake enable or status write not taken.");

  data_scale_a: assert property (
    @(posedge clk) disable iff (reset) pm_control_status[14:13] == 2'b00)
    else $error("Data scale not zero.");

  ext_pin_a: assert property (
    @(posedge clk) disable iff (reset)
      cfg_rd && cfg_addr == pmcr_pkg::ADDR_BSE |=>
      cfg_rdata == {{2{$past(bus_power_clock_ctrl_pin)}}, 6'h00})
    else $error("Extension byte does not show the pin.");

  data_lock_a: assert property (
    @(posedge clk) disable iff (reset)
      cfg_wr && !eeprom_load && !readonly_write_unlock_ctrl &&
      cfg_addr == pmcr_pkg::ADDR_DATA |=> $stable(pm_data_byte))
    else $error("Locked data byte changed.");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (reset)
      pm_capabilities[8:6] == 3'h0 && pm_control_status[7:2] == 6'h00)
    else $error("Reserved bits not zero.");

endmodule
`default_nettype wire

/* dv/pmcr_host.sv */
// Model of the configuration host and EEPROM loader on the register port.
`timescale 1ns/1ns
`default_nettype none
module pmcr_host (
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  output logic eeprom_load,
  output logic [7:0] eeprom_data,
  output logic unlock
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    eeprom_load = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    eeprom_data = 8'h00;
    unlock = 1'b0;
  end

  // ==========================================================================
  // Requests
  // Each strobe lasts one cycle. Released lines show the inverse of the last
  // value, so a stale value can never pass for a fresh one.
  task automatic req(input logic w, input logic r, input logic e,
                     input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= r;
    eeprom_load <= e;
    cfg_addr <= a;
    cfg_wdata <= d;
    eeprom_data <= ~d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    eeprom_load <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    eeprom_data <= d;
  endtask

  // Callers clear the unlock again once their changes are made.
  task automatic set_unlock(input logic v);
    @(posedge clk);
    unlock <= v;
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the power management capability registers.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset, pin, rd_seen;
  logic cfg_wr, cfg_rd, eeprom_load, unlock;
  logic [7:0] cfg_addr, cfg_wdata, eeprom_data, cfg_rdata, r, w;
  logic [4:0] sclk;
  logic [15:0] cap, csr;
  logic [7:0] dbyte;
  logic [7:0] exp_q[$];
  logic [7:0] lk[7] = '{8'h01, 8'h7e, 8'h03, 8'h81, 8'hc0, 8'h00, 8'h00};
  logic [7:0] m[7] = '{8'h3f, 8'hfe, 8'h00, 8'h9f, 8'h00, 8'hff, 8'h00};
  logic [31:0] seed;
  int bad_count, checks, cycles;

  always #20 clk = ~clk;

  pmcr_host i_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .eeprom_load(eeprom_load),
    .eeprom_data(eeprom_data), .unlock(unlock));

  pmcr_regs i_dut (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .eeprom_load(eeprom_load),
    .eeprom_addr(cfg_addr), .eeprom_data(eeprom_data),
    .readonly_write_unlock_ctrl(unlock), .bus_power_clock_ctrl_pin(pin),
    .secondary_clock_outputs(sclk), .pm_capabilities(cap),
    .pm_control_status(csr), .pm_data_byte(dbyte));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.req(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Read data monitor
  // Read data lands at the edge after the strobe, so look half a cycle later.
  always @(posedge clk) rd_seen <= cfg_rd & ~reset;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("mismatch at %0t: read data with nothing expected", $time);
      end else begin
        chk(cfg_rdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      summarize();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h000111e8;
    reset = 1'b1;
    pin = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(8'hde, 8'h01);
    rd(8'hdf, 8'h7e);
    rd(8'he0, 8'h00);
    rd(8'he1, 8'h00);
    rd(8'he3, 8'h00);
    rd(8'he4, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        pin <= p[0];
        i_host.req(1'b1, 1'b0, 1'b0, 8'he0, {6'h00, s[1:0]});
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({3'h0, sclk}, (s == 3 && p == 1) ? 8'h00 : 8'h1f);
        @(posedge clk);
        rd(8'he0, {6'h00, s[1:0]});
        rd(8'he2, {p[0], p[0], 6'h00});
      end
    end
    // Locked writes reach only the power state and wake bits.
    for (int a = 0; a < 7; a++) begin
      i_host.req(1'b1, 1'b0, 1'b0, 8'(8'hde + a), 8'hff);
    end
    for (int a = 0; a < 7; a++) begin
      rd(8'(8'hde + a), lk[a]);
    end
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      r = seed[7:0];
      i_host.set_unlock(k < 3);
      for (int a = 0; a < 7; a++) begin
        // Power state is written as D0 so D1 and D2 are never chosen unsupported.
        w = (a == 2) ? (r & 8'hfc) : r;
        i_host.req(k < 3, 1'b0, k >= 3, 8'(8'hde + a),
          (k < 3) ? w : ~w);
      end
      for (int a = 0; a < 7; a++)
        rd(8'(8'hde + a), (r & m[a]) | ((a == 4) ? 8'hc0 : 8'h00));
    end
    // The loader wins over a configuration write in the same cycle.
    i_host.req(1'b1, 1'b0, 1'b1, 8'he3, 8'h5a);
    rd(8'he3, 8'ha5);
    repeat (3) @(posedge clk);
    // The word outputs must agree with the last loads, looked at mid-cycle.
    @(negedge clk);
    chk(dbyte, 8'ha5);
    chk(cap[7:0], r & m[0]);
    chk(cap[15:8], r & m[1]);
    chk(csr[15:8], r & m[3]);
    chk(csr[7:0], 8'h00);
    chk({3'h0, sclk}, 8'h1f);
    summarize();
  end
endmodule
`default_nettype wire
